/* rtl/sbr_pkg.sv */
package sbr_pkg;
	// read configuration word, field order as held in the register
	typedef struct packed {
		logic       readModeSelect;
		logic       rsvHigh;
		logic [2:0] firstAccessLatencyCode;
		logic       waitLevelSelect;
		logic       dataHoldSelect;
		logic       readyEarlySelect;
		logic       burstOrderSelect;
		logic       activeEdgeSelect;
		logic [1:0] rsvMid;
		logic       burstNoWrap;
		logic [2:0] burstLengthCode;
	} sbr_cfg_s;

	localparam logic [15:0] CFG_RESET = 16'hbfcf;
	localparam logic [2:0]  LC_MIN    = 3'h2;
	localparam logic [2:0]  BL_4      = 3'h1;
	localparam logic [2:0]  BL_8      = 3'h2;
	localparam logic [2:0]  BL_16     = 3'h3;
	localparam logic [2:0]  BL_CONT   = 3'h7;
	localparam logic [4:0]  WORDS_4   = 5'h04;
	localparam logic [4:0]  WORDS_8   = 5'h08;
	localparam logic [4:0]  WORDS_16  = 5'h10;
	localparam logic [1:0]  HOLD_ONE  = 2'h1;
	localparam logic [1:0]  HOLD_TWO  = 2'h2;

	// register map, byte addresses
	localparam logic [7:0] REG_CFG    = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// burst engine states
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b001,
		ST_LATENCY = 3'b010,
		ST_DATA    = 3'b100
	} sbr_state_e;

	// bus-side register file state
	typedef struct packed {
		logic        awPend;
		logic [7:0]  awAddr;
		logic        wPend;
		logic [31:0] wData;
		logic [3:0]  wStrb;
		logic        bValid;
		logic [1:0]  bResp;
		logic        rValid;
		logic [31:0] rData;
		logic [1:0]  rResp;
		sbr_cfg_s    cfg;
	} sbr_regs_s;
endpackage

/* rtl/sbr_axil_regs.sv */
`timescale 1ns/1ps
module sbr_axil_regs (
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              reset_n,
	// write address and data
	input  wire logic [7:0]        awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	// write response
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// read channels
	input  wire logic [7:0]        araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// block side
	input  wire logic [31:0]       statusWord,
	output sbr_pkg::sbr_cfg_s      cfg
);
	sbr_pkg::sbr_regs_s q, d;

	// 0 config, 1 status, 2 unmapped; shared by both paths
	function automatic logic [1:0] decode(input logic [7:0] a);
		if (a == sbr_pkg::REG_CFG)
			return 2'h0;
		else if (a == sbr_pkg::REG_STATUS)
			return 2'h1;
		return 2'h2;
	endfunction

	// reserved codes keep the old field so the engine never sees them
	function automatic sbr_pkg::sbr_cfg_s clean(input sbr_pkg::sbr_cfg_s o, input sbr_pkg::sbr_cfg_s n);
		sbr_pkg::sbr_cfg_s r;
		r = n;
		r.rsvHigh = 1'b0;
		r.rsvMid = '0;
		r.burstOrderSelect = 1'b1; // only linear order exists
		if (n.firstAccessLatencyCode < sbr_pkg::LC_MIN)
			r.firstAccessLatencyCode = o.firstAccessLatencyCode;
		if (n.burstLengthCode != sbr_pkg::BL_4 && n.burstLengthCode != sbr_pkg::BL_8 &&
		    n.burstLengthCode != sbr_pkg::BL_16 && n.burstLengthCode != sbr_pkg::BL_CONT)
			r.burstLengthCode = o.burstLengthCode;
		return r;
	endfunction

	// one write and one read outstanding; response waits on both halves
	always_comb begin
		sbr_pkg::sbr_cfg_s m;
		m = q.cfg;
		d = q;
		if (awvalid && awready) begin
			d.awPend = 1'b1;
			d.awAddr = awaddr;
		end
		if (wvalid && wready) begin
			d.wPend = 1'b1;
			d.wData = wdata;
			d.wStrb = wstrb;
		end
		if (bvalid && bready)
			d.bValid = 1'b0;
		if (q.awPend && q.wPend && !q.bValid) begin
			if (q.wStrb[0])
				m[7:0] = q.wData[7:0];
			if (q.wStrb[1])
				m[15:8] = q.wData[15:8];
			if (decode(q.awAddr) == 2'h0)
				d.cfg = clean(q.cfg, m);
			d.bResp = (decode(q.awAddr) == 2'h2) ? sbr_pkg::RESP_SLVERR : sbr_pkg::RESP_OKAY;
			d.bValid = 1'b1;
			d.awPend = 1'b0;
			d.wPend = 1'b0;
		end
		if (rvalid && rready)
			d.rValid = 1'b0;
		if (arvalid && arready) begin
			d.rValid = 1'b1;
			d.rResp = sbr_pkg::RESP_OKAY;
			case (decode(araddr))
				2'h0: d.rData = {16'h0000, q.cfg};
				2'h1: d.rData = statusWord;
				default: begin
					d.rData = '0;
					d.rResp = sbr_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			q <= '0;
			q.cfg <= sbr_pkg::CFG_RESET;
		end else begin
			q <= d;
		end
	end

	// handshake outputs
	assign awready = !q.awPend && !q.bValid;
	assign wready  = !q.wPend && !q.bValid;
	assign arready = !q.rValid;
	assign bvalid  = q.bValid;
	assign bresp   = q.bResp;
	assign rvalid  = q.rValid;
	assign rdata   = q.rData;
	assign rresp   = q.rResp;
	assign cfg     = q.cfg;
endmodule

/* rtl/sbr_burst_read_ctrl.sv */
`timescale 1ns/1ps
// Summary of operation
// - first word after programmed latency count edges
// - no wait states inside burst after latency
// - wait-level bit sets asserted ready level
// - synchronous mode: ready changes only on active bus edges
// - synchronous mode: ready deasserted only with data
// - non-array row-end ready valid first access only
// - asynchronous reads hold ready at deasserted level
// - ready asserted until valid; floats when deselected
// - writes with output enable high float ready
// - data hold bit: two or one clocks
// - early bit: ready drops one data cycle sooner
// - only linear burst order is supported
// - wrap mode wraps inside aligned burst block
// - no-wrap mode increments across burst boundaries
// - edge bit picks rising or falling clock
// - length field selects 4, 8, 16, continuous
// - continuous burst runs linear to space end
// - read-mode bit: asynchronous page or synchronous
// - latency codes 2 to 7; others reserved
module sbr_burst_read_ctrl #(
	parameter int ADDR_W = 16
) (
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              reset_n,
	// register bus
	input  wire logic [7:0]        awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [7:0]        araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// host memory bus pins
	input  wire logic              burstClk,
	input  wire logic              chipEnableN,
	input  wire logic              outputEnableN,
	input  wire logic              addressValidStrobeN,
	input  wire logic [ADDR_W-1:0] addrIn,
	// data and ready pins
	output logic [15:0]            dataOut,
	output logic                   dataOe,
	output logic                   waitOut,
	output logic                   waitOe,
	// array side
	input  wire logic              nonArrayRead,
	output logic [ADDR_W-1:0]      arrayAddr,
	input  wire logic [15:0]       arrayData
);
	typedef struct packed {
		sbr_pkg::sbr_state_e st;
		logic                clkPrev;
		logic                advPrev;
		logic [2:0]          latCnt;
		logic [1:0]          holdCnt;
		logic [4:0]          wordsLeft;
		logic                cont;
		logic [ADDR_W-1:0]   addr;
		logic                load;
		logic                dataValid;
		logic [15:0]         dataOut;
		logic                waitAct;
		logic                waitLevel;
	} sbr_core_s;

	sbr_core_s         q, d;
	sbr_pkg::sbr_cfg_s cfg;
	logic [31:0]       statusWord;
	logic              burstEdge;
	logic              advRise;
	logic              busActive;
	logic              advance;
	logic [1:0]        holdLen;

	// register file on the bus
	sbr_axil_regs u_regs (
		.clk_sys    (clk_sys),
		.reset_n    (reset_n),
		.awaddr     (awaddr),
		.awvalid    (awvalid),
		.awready    (awready),
		.wdata      (wdata),
		.wstrb      (wstrb),
		.wvalid     (wvalid),
		.wready     (wready),
		.bresp      (bresp),
		.bvalid     (bvalid),
		.bready     (bready),
		.araddr     (araddr),
		.arvalid    (arvalid),
		.arready    (arready),
		.rdata      (rdata),
		.rresp      (rresp),
		.rvalid     (rvalid),
		.rready     (rready),
		.statusWord (statusWord),
		.cfg        (cfg)
	);

	// words in a fixed burst; continuous gives zero
	function automatic logic [4:0] burstWords(input logic [2:0] code);
		case (code)
			sbr_pkg::BL_4:  return sbr_pkg::WORDS_4;
			sbr_pkg::BL_8:  return sbr_pkg::WORDS_8;
			sbr_pkg::BL_16: return sbr_pkg::WORDS_16;
			default:        return '0;
		endcase
	endfunction

	// low address bits that wrap inside the aligned block
	function automatic logic [ADDR_W-1:0] wrapMask(input logic [2:0] code);
		logic [4:0] w;
		w = burstWords(code) - 5'h01;
		return ADDR_W'(w);
	endfunction

	// linear next address, wrapping only for fixed lengths with wrap on
	function automatic logic [ADDR_W-1:0] nextAddr(input logic [ADDR_W-1:0] a,
		input logic [2:0] code, input logic noWrap);
		logic [ADDR_W-1:0] inc;
		logic [ADDR_W-1:0] m;
		inc = a + ADDR_W'(1);
		m = wrapMask(code);
		if (noWrap || code == sbr_pkg::BL_CONT)
			return inc;
		return (a & ~m) | (inc & m);
	endfunction

	// active edge of the sampled host clock; host clock must be well below clk_sys
	assign burstEdge = cfg.activeEdgeSelect ? (burstClk && !q.clkPrev)
		: (!burstClk && q.clkPrev);
	assign advRise   = addressValidStrobeN && !q.advPrev;
	assign busActive = !chipEnableN && !outputEnableN;
	assign holdLen   = cfg.dataHoldSelect ? sbr_pkg::HOLD_TWO : sbr_pkg::HOLD_ONE;
	assign advance   = !chipEnableN && !cfg.readModeSelect && !advRise && burstEdge
		&& q.st == sbr_pkg::ST_DATA && q.holdCnt + 2'h1 == holdLen;

	// burst engine: latency count, data cycles, address stepping
	always_comb begin
		d = q;
		d.clkPrev = burstClk;
		d.advPrev = addressValidStrobeN;
		d.load = 1'b0;
		if (q.load)
			d.dataOut = arrayData; // array answers one cycle after the address
		if (chipEnableN) begin
			d.st = sbr_pkg::ST_IDLE;
			d.dataValid = 1'b0;
			d.waitAct = 1'b0;
		end else if (cfg.readModeSelect) begin
			// asynchronous mode: address flows through, ready never asserts
			d.st = sbr_pkg::ST_IDLE;
			d.waitAct = 1'b0;
			d.dataValid = 1'b1;
			d.load = 1'b1;
			if (!addressValidStrobeN)
				d.addr = addrIn;
		end else if (advRise) begin
			d.addr = addrIn;
			d.st = sbr_pkg::ST_LATENCY;
			d.latCnt = cfg.firstAccessLatencyCode;
			d.holdCnt = '0;
			d.dataValid = 1'b0;
			d.wordsLeft = burstWords(cfg.burstLengthCode);
			d.cont = cfg.burstLengthCode == sbr_pkg::BL_CONT;
		end else if (burstEdge) begin
			case (q.st)
				sbr_pkg::ST_LATENCY: begin
					d.latCnt = q.latCnt - 3'h1;
					if (q.latCnt == 3'h1) begin
						d.st = sbr_pkg::ST_DATA;
						d.dataValid = 1'b1;
						d.load = 1'b1;
						d.holdCnt = '0;
					end
				end
				sbr_pkg::ST_DATA: begin
					d.holdCnt = q.holdCnt + 2'h1;
					if (advance) begin
						d.holdCnt = '0;
						d.load = 1'b1;
						// status, identifier and query reads repeat one word; no row end to cross
						if (!nonArrayRead)
							d.addr = nextAddr(q.addr, cfg.burstLengthCode, cfg.burstNoWrap);
						if (!q.cont)
							d.wordsLeft = q.wordsLeft - 5'h01;
						if ((!q.cont && q.wordsLeft == 5'h01) || (q.cont && q.addr == '1)) begin
							d.st = sbr_pkg::ST_IDLE;
							d.dataValid = 1'b0;
						end
					end
				end
				default: d.st = sbr_pkg::ST_IDLE;
			endcase
			// no row-end stalls: ready is only asserted during latency
			d.waitAct = d.st == sbr_pkg::ST_LATENCY &&
				!(cfg.readyEarlySelect && d.latCnt <= 3'(holdLen));
		end
		// in synchronous mode the pin level moves only on an active edge of an active cycle; asynchronous mode sets it every cycle
		if (cfg.readModeSelect)
			d.waitLevel = !cfg.waitLevelSelect;
		else if (burstEdge && busActive)
			d.waitLevel = d.waitAct ~^ cfg.waitLevelSelect;
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			q <= '0;
			q.st <= sbr_pkg::ST_IDLE;
			q.clkPrev <= 1'b0; // idle level of the host clock, so no false falling edge after reset
			q.advPrev <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// pin drivers; ready floats whenever either enable is high
	assign dataOut   = q.dataOut;
	assign dataOe    = busActive && q.dataValid;
	assign waitOut   = q.waitLevel;
	assign waitOe    = busActive;
	assign arrayAddr = q.addr;
	assign statusWord = 32'({q.addr, 8'h00, 3'h0, q.waitAct, q.dataValid, q.st});

	// helper counters seen only by the checks below
	logic [3:0] latEdges_q;
	logic [1:0] edgeSince_q;
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			latEdges_q <= '0;
			edgeSince_q <= '0;
		end else begin
			if (advRise)
				latEdges_q <= '0;
			else if (burstEdge && q.st == sbr_pkg::ST_LATENCY)
				latEdges_q <= latEdges_q + 4'h1;
			if (advRise || advance || q.st != sbr_pkg::ST_DATA)
				edgeSince_q <= '0;
			else if (burstEdge)
				edgeSince_q <= edgeSince_q + 2'h1;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	// first word appears on exactly the programmed edge count
	property p_first_latency;
		$rose(q.st == sbr_pkg::ST_DATA) && !cfg.readModeSelect
			|-> latEdges_q == 4'(q.latCnt == '0 ? $past(cfg.firstAccessLatencyCode) : 3'h0);
	endproperty
	a_first_latency: assert property (p_first_latency) else $error("first word latency wrong");

	// asserted level follows the polarity bit while waiting
	property p_wait_level;
		!cfg.readModeSelect && q.waitAct && busActive ##1 burstEdge && busActive
			|=> waitOut == cfg.waitLevelSelect || !q.waitAct;
	endproperty
	a_wait_level: assert property (p_wait_level) else $error("ready level against polarity");

	// pin level never moves between active edges in synchronous mode
	property p_wait_edges;
		!cfg.readModeSelect && !$past(cfg.readModeSelect) && $changed(waitOut)
			|-> $past(burstEdge) && $past(busActive);
	endproperty
	a_wait_edges: assert property (p_wait_edges) else $error("ready moved off an edge");

	// once data flows no wait is inserted
	property p_no_stall;
		q.st == sbr_pkg::ST_DATA |-> !q.waitAct && q.dataValid;
	endproperty
	a_no_stall: assert property (p_no_stall) else $error("wait state inside burst");

	// asynchronous mode drives the deasserted level
	property p_async_level;
		cfg.readModeSelect && $past(cfg.readModeSelect) && waitOe
			|-> waitOut == !cfg.waitLevelSelect;
	endproperty
	a_async_level: assert property (p_async_level) else $error("ready asserted in async mode");

	// ready is released whenever either enable is high
	property p_float;
		chipEnableN || outputEnableN |-> !waitOe && !dataOe;
	endproperty
	a_float: assert property (p_float) else $error("pin driven while deselected");

	// each word stands for exactly the hold setting in edges
	property p_hold;
		advance |-> 2'(edgeSince_q + 2'h1) == holdLen;
	endproperty
	a_hold: assert property (p_hold) else $error("data cycle length wrong");

	// late ready stays asserted from the first latency edge until the first word
	property p_late_ready;
		q.st == sbr_pkg::ST_LATENCY && !cfg.readyEarlySelect && !$past(advRise) && latEdges_q != '0
			|-> q.waitAct;
	endproperty
	a_late_ready: assert property (p_late_ready) else $error("ready dropped early");

	// wrapped bursts keep the aligned block
	property p_wrap;
		advance && !cfg.burstNoWrap && cfg.burstLengthCode != sbr_pkg::BL_CONT && !nonArrayRead
			|=> (q.addr & ~wrapMask(cfg.burstLengthCode))
				== ($past(q.addr) & ~wrapMask(cfg.burstLengthCode));
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap left its block");

	// linear bursts step by one word
	property p_linear;
		advance && !nonArrayRead && (cfg.burstNoWrap || cfg.burstLengthCode == sbr_pkg::BL_CONT)
			|=> q.addr == $past(q.addr) + ADDR_W'(1);
	endproperty
	a_linear: assert property (p_linear) else $error("linear step wrong");

	// deselect ends the burst on the next cycle
	property p_abort;
		chipEnableN |=> q.st == sbr_pkg::ST_IDLE && !dataOe;
	endproperty
	a_abort: assert property (p_abort) else $error("burst kept after deselect");

	// main scenarios
	c_four_word: cover property (advance && q.wordsLeft == 5'h01 && cfg.burstLengthCode == sbr_pkg::BL_4);
	c_cont: cover property (advance && q.cont);
	c_early: cover property (q.st == sbr_pkg::ST_LATENCY && !q.waitAct && cfg.readyEarlySelect);
	c_falling: cover property (advance && !cfg.activeEdgeSelect);
endmodule

/* test/sbr_host_model.sv */
`timescale 1ns/1ps
// host memory controller; its burst clock stands still low between frames
module sbr_host_model (
	// system clock
	input  wire logic   clk_sys,
	// flash bus pins
	output logic        burstClk,
	output logic        chipEnableN,
	output logic        outputEnableN,
	output logic        addressValidStrobeN,
	output logic [15:0] addrIn
);
	// deselected at start
	initial begin
		burstClk = 1'b0;
		chipEnableN = 1'b1;
		outputEnableN = 1'b1;
		addressValidStrobeN = 1'b1;
		addrIn = 16'h0000;
	end
	// one frame of nPer clock periods of 8 system clocks (12.5 MHz)
	// slow enough for every latency code and for one-clock hold
	task automatic frame(input logic [15:0] a, input int nPer);
		@(posedge clk_sys);
		chipEnableN <= 1'b0;
		outputEnableN <= 1'b0;
		addressValidStrobeN <= 1'b0;
		addrIn <= a;
		repeat (4) @(posedge clk_sys);
		addressValidStrobeN <= 1'b1;
		repeat (2) @(posedge clk_sys);
		addrIn <= ~a; // hold over, so the old address is gone
		repeat (2) @(posedge clk_sys);
		repeat (nPer) begin
			burstClk <= 1'b1;
			repeat (4) @(posedge clk_sys);
			burstClk <= 1'b0;
			repeat (4) @(posedge clk_sys);
		end
		chipEnableN <= 1'b1;
		outputEnableN <= 1'b1;
	endtask
endmodule

/* test/sbr_burst_read_ctrl_tb_top.sv */
`timescale 1ns/1ps
module sbr_burst_read_ctrl_tb_top;
	logic        clk_sys, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, dataOe, waitOut, waitOe, pol;
	logic        burstClk, chipEnableN, outputEnableN, addressValidStrobeN;
	logic        advPrev = 1'b1, syncMode = 1'b0, firstWord = 1'b0;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, lfsr = 32'h0927;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [15:0] addrIn, dataOut, arrayAddr, arrayData, prevData = 16'h0000;
	logic [33:0] rq[$];
	logic [1:0]  bq[$];
	logic [15:0] wq[$];
	int          nMismatch = 0, checkCount = 0, cyc = 0, tRise = 0, tLast = 0, holdCyc, latLo;
	// lc2 is never paired with two-clock hold and early ready
	logic [15:0] cfgTab[4] = '{16'h1fc1, 16'h108a, 16'h26c3, 16'h39cf};

	// clock
	initial clk_sys = 1'b0;
	always #5 clk_sys = ~clk_sys;
	// array answers with an address-derived word
	assign arrayData = arrayAddr ^ 16'h5a3c;

	sbr_burst_read_ctrl #(.ADDR_W(16)) u_dut (
		.clk_sys, .reset_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.burstClk, .chipEnableN, .outputEnableN, .addressValidStrobeN, .addrIn,
		.dataOut, .dataOe, .waitOut, .waitOe, .nonArrayRead(1'b0), .arrayAddr, .arrayData
	);
	sbr_host_model u_host (.clk_sys, .burstClk, .chipEnableN, .outputEnableN, .addressValidStrobeN, .addrIn);

	function automatic logic [31:0] nextRand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic cmpWord(input logic [15:0] got, input logic [15:0] exp);
		checkCount++;
		if (got !== exp) begin
			nMismatch++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cmpBus(input logic [33:0] got, input logic [33:0] exp);
		checkCount++;
		if (got !== exp) begin
			nMismatch++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic completeRun();
		$display("mismatches %0d checks %0d", nMismatch, checkCount);
		if (nMismatch == 0 && checkCount > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// both write channels offered together, each dropped once taken
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
		bq.push_back(resp);
		@(posedge clk_sys);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hf;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
	endtask

	task automatic axiRead(input logic [7:0] a, input logic [33:0] exp);
		rq.push_back(exp);
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
	endtask

	// one synchronous burst; expected words follow the wrap rules
	task automatic burst(input logic [15:0] cfg, input logic [15:0] a);
		int n;
		int hold;
		axiWrite(sbr_pkg::REG_CFG, {16'h0000, cfg}, sbr_pkg::RESP_OKAY);
		axiRead(sbr_pkg::REG_CFG, {sbr_pkg::RESP_OKAY, 16'h0000, cfg});
		n = cfg[2:0] == sbr_pkg::BL_4 ? int'(sbr_pkg::WORDS_4) : cfg[2:0] == sbr_pkg::BL_8 ?
			int'(sbr_pkg::WORDS_8) : cfg[2:0] == sbr_pkg::BL_16 ? int'(sbr_pkg::WORDS_16) : 65536 - int'(a);
		hold = cfg[9] ? 2 : 1;
		holdCyc = 8 * hold;
		latLo = 8 * (int'(cfg[13:11]) - 1) + 4 + (cfg[6] ? 0 : 4);
		pol = cfg[10];
		for (int i = 0; i < n; i++)
			wq.push_back(16'((cfg[3] || cfg[2:0] == sbr_pkg::BL_CONT) ? int'(a) + i :
				(int'(a) & ~(n - 1)) | ((int'(a) + i) & (n - 1))) ^ 16'h5a3c);
		firstWord = 1'b1;
		syncMode = 1'b1;
		u_host.frame(a, int'(cfg[13:11]) + n * hold + 2);
		repeat (4) @(posedge clk_sys);
		cmpBus(34'(wq.size()), 34'h0);
		cmpBus(34'(waitOe), 34'h0);
		syncMode = 1'b0;
	endtask

	// watcher: takes the oldest note whenever a result shows
	always @(posedge clk_sys) begin
		cyc++;
		if (bvalid && bready)
			cmpBus({32'h0, bresp}, {32'h0, bq.pop_front()});
		if (rvalid && rready)
			cmpBus({rresp, rdata}, rq.pop_front());
		if (!advPrev && addressValidStrobeN)
			tRise = cyc;
		advPrev = addressValidStrobeN;
		if (syncMode && dataOe && dataOut !== prevData) begin
			cmpWord(dataOut, wq.pop_front());
			cmpBus(34'(waitOut), 34'(!pol));
			if (firstWord)
				cmpBus(34'((cyc - tRise) inside {[latLo:latLo + 6]}), 34'h1);
			else
				cmpBus(34'(cyc - tLast), 34'(holdCyc));
			firstWord = 1'b0;
			tLast = cyc;
		end
		prevData = dataOut;
	end

	// main sequence
	initial begin
		reset_n = 1'b0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		repeat (12) @(posedge clk_sys);
		reset_n <= 1'b1;
		axiRead(sbr_pkg::REG_CFG, {sbr_pkg::RESP_OKAY, 16'h0000, sbr_pkg::CFG_RESET});
		for (int i = 0; i < 4; i++) begin
			lfsr = nextRand(lfsr);
			burst(cfgTab[i], i == 3 ? 16'hfffd : lfsr[15:0] & 16'h7fff);
		end
		// page mode with low polarity: ready parked high
		axiWrite(sbr_pkg::REG_CFG, 32'h0000bbcf, sbr_pkg::RESP_OKAY);
		u_host.frame(lfsr[31:16], 6);
		cmpBus(34'(waitOut), 34'h1);
		// status: address taken while the strobe was low, idle state, no word valid
		axiRead(sbr_pkg::REG_STATUS, {sbr_pkg::RESP_OKAY, lfsr[31:16], 16'h0001});
		// reserved codes keep old fields, order bit stays linear
		axiWrite(sbr_pkg::REG_CFG, 32'h0000c37c, sbr_pkg::RESP_OKAY);
		axiRead(sbr_pkg::REG_CFG, {sbr_pkg::RESP_OKAY, 32'h0000bbcf});
		axiWrite(8'h08, 32'h0, sbr_pkg::RESP_SLVERR);
		axiRead(8'h08, {sbr_pkg::RESP_SLVERR, 32'h0});
		repeat (4) @(posedge clk_sys);
		completeRun();
	end

	// watchdog at 5000 cycles, well past the fewer than one thousand cycles the run needs
	initial begin
		#50000;
		nMismatch++;
		$display("Error t=%0t watchdog expired", $time);
		completeRun();
	end
endmodule
